// ===== src/npe_status.sv
// Mode and sector status registers of a NAND page error-checking unit.
// Assumes the parity engine reports one outcome per sector after its last word and code.
//
// Contract
// R01 - Two-bit selector picks page length
// R02 - Page word is 8 or 16 bits
// R03 - Granularity 00 covers the whole page
// R04 - Granularity 01 checks each 256-byte sector
// R05 - Granularity 10 checks each 512-byte sector
// R06 - Status nibble per sector, bit 3 reserved
// R07 - Recoverable flag set on any detected error; code sets it for single and multiple errors, not code-byte errors
// R08 - Multiple flag only on more than one error
// R09 - Code-byte flag for error in stored code
// R10 - Sector 0 code error mask placement
// R11 - Sector n code error mask placement
// R12 - Sectors 1-7 flags zero in whole-page mode
// R13 - Sector n maps to its byte range
// R14 - Clear results on command or software reset
// R15 - Control bit 0 one clears, zero ignored
// R16 - Report word offset and bit position
// R17 - Flags change only after whole sector
`timescale 1ns/100ps
module npe_status
	import npe_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic bus_wide16,
	input wire logic nand_cmd_seen,
	input wire logic chk_done,
	input wire npe_kind_e chk_kind,
	input wire logic [WORD_W-1:0] chk_last_word,
	input wire logic [WORD_W-1:0] chk_err_word,
	input wire logic [3:0] chk_err_bit,
	input wire logic [31:0] chk_code_mask,
	output logic parity_clear,
	output logic irq
);
	// Bus sequencing
	npe_bus_e bus_state_r;
	npe_bus_e bus_state_nxt;
	logic waitreq_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	// Software registers and block state
	logic [31:0] mode_r;
	logic [31:0] stat_r;
	logic [31:0] stat_nxt;
	logic [SECTORS-1:0] pr_valid_r;
	logic [SECTORS-1:0] pr_valid_nxt;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_stat_nxt;
	logic [3:0] irq_mask_r;
	logic irq_r;
	logic par_clr_r;

	// Byte lanes into a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Parity result slot for a register offset, used by bus decode
	function automatic logic [2:0] pr_slot(input logic [7:0] ofs);
		logic [7:0] d;
		d = 8'h00;
		if (ofs == OFS_PR0) begin
			pr_slot = 3'h0;
		end else if (ofs == OFS_PR1) begin
			pr_slot = 3'h1;
		end else begin
			d = ofs - OFS_PR2;
			pr_slot = 3'(d[7:2] + 6'h02);
		end
	endfunction

	// Mode fields
	wire [1:0] page_length_sel = mode_r[MODE_PAGE_LSB +: 2];
	wire [1:0] correction_granularity = mode_r[MODE_GRAN_LSB +: 2];
	wire whole_page = (correction_granularity != GRAN_256) &&
		(correction_granularity != GRAN_512); // see R03

	// Data bytes in the page: 512, 1024, 2048 or 4096 by selector
	wire [13:0] page_bytes = PAGE_BYTES_MIN << page_length_sel; // see R01

	// Byte address of the sector's last word, doubled plus one for 16-bit parts
	wire [13:0] last_byte = bus_wide16 ? {chk_last_word, 1'b1} :
		{1'b0, chk_last_word}; // see R02

	// Sector number from byte address by granularity
	wire [4:0] sect_wide = (correction_granularity == GRAN_256) ? 5'(last_byte >> 8) :
		(correction_granularity == GRAN_512) ? 5'(last_byte >> 9) : 5'h00; // see R04 R05 R13
	wire [2:0] sect = sect_wide[2:0];
	wire sect_ok = (sect_wide < 5'd8) && (last_byte < page_bytes) &&
		(whole_page ? (sect_wide == 5'h00) : 1'b1); // see R12

	// Outcome decode
	wire is_single = chk_kind == KIND_SINGLE;
	wire is_code = chk_kind == KIND_CODE;
	wire is_multi = chk_kind == KIND_MULTI;
	wire take = chk_done && sect_ok; // see R17

	// Nibble for this outcome; bit 3 always zero
	wire [3:0] nib = {1'b0, is_multi, is_code, is_single | is_multi}; // see R06 R07 R08 R09

	// Result word for the sector: position of a single or multiple error, or code-byte mask
	wire [31:0] pr_word = is_code ? {8'h00, chk_code_mask[23:0]} :
		{15'h0000, chk_err_word, chk_err_bit}; // see R11 R16
	wire [31:0] pr0_code_page = {16'h0000, chk_code_mask[15:0]}; // see R10
	wire [31:0] pr1_code_page = {16'h0000, chk_code_mask[31:16]}; // see R10
	wire page_code = take && is_code && whole_page;

	// Memory write selection; the whole-page code error spans two words
	logic pr1_pend_r;
	logic [31:0] pr1_hold_r;
	wire mem_wr = (take && (chk_kind != KIND_NONE)) || pr1_pend_r;
	wire [2:0] mem_waddr = pr1_pend_r ? 3'h1 : sect;
	wire [31:0] mem_wdata = pr1_pend_r ? pr1_hold_r :
		(page_code ? pr0_code_page : pr_word);

	// Bus decode
	wire req = avs_read || avs_write;
	wire hit_ctrl = avs_address == OFS_CTRL;
	wire hit_mode = avs_address == OFS_MODE;
	wire hit_stat = avs_address == OFS_STAT;
	wire hit_pr = (avs_address == OFS_PR0) || (avs_address == OFS_PR1) ||
		((avs_address >= OFS_PR2) && (avs_address <= OFS_PR7) &&
		(avs_address[1:0] == 2'b00));
	wire hit_istat = avs_address == OFS_IRQ_STAT;
	wire hit_imask = avs_address == OFS_IRQ_MASK;
	wire [2:0] rd_slot = pr_slot(avs_address);
	wire [31:0] wmask = lane_mask(avs_byteenable);
	wire wr_now = (bus_state_r == BUS_ANSWER) && avs_write;

	// Clearing sources: new memory command or software reset
	wire sw_clr = wr_now && hit_ctrl && avs_byteenable[0] &&
		avs_writedata[CTRL_RST_BIT]; // see R15
	wire clr = sw_clr || nand_cmd_seen; // see R14

	// Result store
	logic [31:0] mem_rdata;
	npe_pr_mem u_mem (
		.core_clk(core_clk),
		.wr_en(mem_wr),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(rd_slot),
		.rd_data_r(mem_rdata)
	);

	// Status next value: clear first, a same-cycle result still lands
	always_comb begin
		stat_nxt = clr ? STAT_RST : stat_r; // see R14
		if (take) begin
			stat_nxt[sect*4 +: 4] = nib; // see R06 R17
		end
	end

	// Valid bits for parity words; set wins over clear
	always_comb begin
		pr_valid_nxt = clr ? '0 : pr_valid_r; // see R14
		if (take && (chk_kind != KIND_NONE)) begin
			pr_valid_nxt[sect] = 1'b1;
		end
		if (page_code) begin
			pr_valid_nxt[1] = 1'b1; // see R10
		end
	end

	// Sticky interrupt events, write one clears, new event wins
	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (wr_now && hit_istat && avs_byteenable[0]) begin
			irq_stat_nxt = irq_stat_r & ~avs_writedata[3:0];
		end
		irq_stat_nxt[EV_SINGLE] = irq_stat_nxt[EV_SINGLE] | (take && is_single);
		irq_stat_nxt[EV_CODE] = irq_stat_nxt[EV_CODE] | (take && is_code);
		irq_stat_nxt[EV_MULTI] = irq_stat_nxt[EV_MULTI] | (take && is_multi);
		irq_stat_nxt[EV_DONE] = irq_stat_nxt[EV_DONE] | take;
	end

	// Read data selection; sectors 1-7 masked in whole-page mode
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (hit_mode) begin
			rdata_nxt = mode_r;
		end else if (hit_stat) begin
			rdata_nxt = whole_page ? {28'h000_0000, stat_r[3:0]} : stat_r; // see R12
		end else if (hit_pr) begin
			rdata_nxt = pr_valid_r[rd_slot] ? mem_rdata : 32'h0000_0000;
		end else if (hit_istat) begin
			rdata_nxt = {28'h000_0000, irq_stat_r};
		end else if (hit_imask) begin
			rdata_nxt = {28'h000_0000, irq_mask_r};
		end
	end

	// Bus sequence: take, fetch from store, answer for one cycle
	always_comb begin
		bus_state_nxt = bus_state_r;
		unique case (bus_state_r)
			BUS_IDLE: begin
				if (req) begin
					bus_state_nxt = BUS_FETCH;
				end
			end
			BUS_FETCH: begin
				bus_state_nxt = BUS_ANSWER;
			end
			BUS_ANSWER: begin
				bus_state_nxt = BUS_IDLE;
			end
			default: begin
				bus_state_nxt = BUS_IDLE;
			end
		endcase
	end

	// Bus state and answer registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_state_r <= BUS_IDLE;
			waitreq_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else begin
			bus_state_r <= bus_state_nxt;
			waitreq_r <= bus_state_nxt != BUS_ANSWER;
			if (bus_state_r == BUS_FETCH) begin
				rdata_r <= avs_read ? rdata_nxt : 32'h0000_0000;
			end
		end
	end

	// Mode register, byte-lane masked
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= MODE_RST;
		end else if (wr_now && hit_mode) begin
			mode_r <= (mode_r & ~wmask) | (avs_writedata & wmask & 32'h0000_0033);
		end
	end

	// Interrupt mask register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_r <= IRQ_RST;
		end else if (wr_now && hit_imask && avs_byteenable[0]) begin
			irq_mask_r <= avs_writedata[3:0];
		end
	end

	// Status, valid bits, interrupt state
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_r <= STAT_RST;
			pr_valid_r <= '0;
			irq_stat_r <= IRQ_RST;
			irq_r <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			pr_valid_r <= pr_valid_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_r <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// Second half of a whole-page code mask goes to word 1 next cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pr1_pend_r <= 1'b0;
			pr1_hold_r <= 32'h0000_0000;
		end else begin
			pr1_pend_r <= page_code; // see R10
			if (page_code) begin
				pr1_hold_r <= pr1_code_page;
			end
		end
	end

	// Parity reset pulse toward the parity engine
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			par_clr_r <= 1'b0;
		end else begin
			par_clr_r <= clr; // see R14 R15
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = waitreq_r;
	assign parity_clear = par_clr_r;
	assign irq = irq_r;
endmodule

// ===== src/npe_pkg.sv
// Constants shared by the NAND page check status block and its result store.
// Assumes a 32-bit register slave and an external parity engine upstream.
package npe_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_PR0 = 8'h0C;
	localparam logic [7:0] OFS_PR1 = 8'h10;
	localparam logic [7:0] OFS_PR2 = 8'h18;
	localparam logic [7:0] OFS_PR7 = 8'h2C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h50;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h54;
	// Field positions
	localparam int CTRL_RST_BIT = 0;
	localparam int MODE_PAGE_LSB = 0;
	localparam int MODE_GRAN_LSB = 4;
	localparam int FLAG_REC = 0;
	localparam int FLAG_CODE = 1;
	localparam int FLAG_MULTI = 2;
	localparam int PR_BIT_LSB = 0;
	localparam int PR_WORD_LSB = 4;
	// Reset values
	localparam logic [31:0] MODE_RST = 32'h0000_0000;
	localparam logic [31:0] STAT_RST = 32'h0000_0000;
	localparam logic [3:0] IRQ_RST = 4'h0;
	// Interrupt event bits
	localparam int EV_SINGLE = 0;
	localparam int EV_CODE = 1;
	localparam int EV_MULTI = 2;
	localparam int EV_DONE = 3;
	// Sizes
	localparam int SECTORS = 8;
	localparam int WORD_W = 13;
	localparam logic [13:0] PAGE_BYTES_MIN = 14'h0200;
	// Correction granularity codes
	localparam logic [1:0] GRAN_PAGE = 2'h0;
	localparam logic [1:0] GRAN_256 = 2'h1;
	localparam logic [1:0] GRAN_512 = 2'h2;
	// Kinds of check outcome reported by the parity engine
	typedef enum logic [1:0] {KIND_NONE, KIND_SINGLE, KIND_CODE, KIND_MULTI} npe_kind_e;
	// Bus answer sequence
	typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ANSWER} npe_bus_e;
endpackage

// ===== src/npe_pr_mem.sv
// Eight-word store for the per-sector parity result words.
// Assumes one writer and one reader in the same clock; read data is registered.
`timescale 1ns/100ps
module npe_pr_mem
	import npe_pkg::*;
(
	input wire logic core_clk,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [31:0] wr_data,
	input wire logic [2:0] rd_addr,
	output logic [31:0] rd_data_r
);
	// Storage array, contents are qualified by valid bits in the parent
	logic [31:0] mem [SECTORS];

	// Write port
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port
	always_ff @(posedge core_clk) begin
		rd_data_r <= mem[rd_addr];
	end
endmodule

// ===== test/npe_status_props.sv
// Port checker for the status block.
// Assumes it is bound to npe_status and sees its ports only.
`timescale 1ns/100ps
module npe_status_props
	import npe_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic nand_cmd_seen,
	input wire logic chk_done,
	input wire logic parity_clear,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Accepted transfers and clear sources
	wire wr_ok = !avs_waitrequest && avs_write;
	wire stat_rd = !avs_waitrequest && avs_read && avs_address == OFS_STAT;
	wire ctl_one = avs_address == OFS_CTRL && avs_writedata[0] && avs_byteenable[0];
	wire clr = nand_cmd_seen || (wr_ok && ctl_one);
	logic [1:0] gran_r;
	logic clean_r;
	// Shadow of the granularity field and of a cleared status
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gran_r <= GRAN_PAGE;
			clean_r <= 1'h1;
		end else begin
			if (wr_ok && avs_address == OFS_MODE && avs_byteenable[0]) gran_r <= avs_writedata[5:4];
			if (chk_done) clean_r <= 1'h0;
			else if (clr) clean_r <= 1'h1;
		end
	end
	a_answer_two: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("late answer");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
	a_clear_pulse: assert property (clr |=> parity_clear) else $error("no clear");
	a_clear_cause: assert property (parity_clear |-> $past(clr)) else $error("stray clear");
	a_page_only: assert property (stat_rd && gran_r != GRAN_256 && gran_r != GRAN_512 |->
		avs_readdata[31:4] == 28'h000_0000) else $error("sector flags in page mode");
	a_rsvd_zero: assert property (stat_rd |->
		(avs_readdata & 32'h8888_8888) == 32'h0000_0000) else $error("reserved bit set");
	a_rec_multi: assert property (stat_rd |->
		((avs_readdata >> 2) & ~avs_readdata & 32'h1111_1111) == 32'h0000_0000) else $error("multi alone");
	a_clean_stat: assert property (stat_rd && clean_r |->
		avs_readdata == 32'h0000_0000) else $error("status not cleared");
	cover property (stat_rd && avs_readdata != 32'h0000_0000);
	cover property (parity_clear);
	cover property (irq);
endmodule

// ===== test/npe_flash_model.sv
// Flash side and parity engine: command pulses and sector reports.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/100ps
module npe_flash_model
	import npe_pkg::*;
(
	input wire logic core_clk,
	input wire logic bus_wide16,
	output logic nand_cmd_seen,
	output logic chk_done,
	output npe_kind_e chk_kind,
	output logic [WORD_W-1:0] chk_last_word,
	output logic [WORD_W-1:0] chk_err_word,
	output logic [3:0] chk_err_bit,
	output logic [31:0] chk_code_mask
);
	// Quiet lines at time zero
	initial begin
		nand_cmd_seen = 1'h0;
		chk_done = 1'h0;
		chk_kind = KIND_NONE;
		chk_last_word = '0;
		chk_err_word = '0;
		chk_err_bit = 4'h0;
		chk_code_mask = 32'h0000_0000;
	end
	// One-cycle new command pulse
	task cmd;
		nand_cmd_seen <= 1'h1;
		@(posedge core_clk);
		nand_cmd_seen <= 1'h0;
		@(posedge core_clk);
	endtask
	// Report sector s of sb bytes after dly idle cycles
	task rep(input npe_kind_e k, input int s, input int sb, input logic [12:0] w,
		input logic [3:0] b, input logic [31:0] m, input int dly);
		int lw;
		lw = (s + 1) * sb / (bus_wide16 ? 2 : 1) - 1;
		repeat (dly) @(posedge core_clk);
		chk_done <= 1'h1;
		chk_kind <= k;
		chk_last_word <= lw[12:0];
		chk_err_word <= w;
		chk_err_bit <= b;
		chk_code_mask <= m;
		@(posedge core_clk);
		// Released lines show the inverse, never a stale value
		chk_done <= 1'h0;
		chk_kind <= npe_kind_e'(~k);
		chk_last_word <= ~lw[12:0];
		chk_err_word <= ~w;
		chk_err_bit <= ~b;
		chk_code_mask <= ~m;
		@(posedge core_clk);
	endtask
endmodule

// ===== test/npe_status_test.sv
// Self-checking bench for the status block.
// Assumes the flash model drives the report side.
`timescale 1ns/100ps
module npe_status_test
	import npe_pkg::*;
;
	logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, chk_code_mask, q;
	logic [3:0] avs_byteenable, chk_err_bit;
	logic bus_wide16, nand_cmd_seen, chk_done, parity_clear, irq;
	npe_kind_e chk_kind;
	logic [WORD_W-1:0] chk_last_word, chk_err_word;
	int n_mismatch = 0;
	int comparisons = 0;
	npe_status i_npe_status (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .bus_wide16,
		.nand_cmd_seen, .chk_done, .chk_kind, .chk_last_word, .chk_err_word, .chk_err_bit,
		.chk_code_mask, .parity_clear, .irq);
	npe_flash_model i_npe_flash_model (.core_clk, .bus_wide16, .nand_cmd_seen, .chk_done,
		.chk_kind, .chk_last_word, .chk_err_word, .chk_err_bit, .chk_code_mask);
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Bus cycle held until waitrequest is sampled low
	// Waits for the answer as long as it takes; only the hang guard ends a wait
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'h0);
		q = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		@(posedge core_clk);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000);
		check(q, e);
	endtask
	// Reset values, read-only and unmapped places
	task t_regs;
		rc(OFS_MODE, MODE_RST);
		bus(1'h1, OFS_STAT, 32'hFFFF_FFFF);
		bus(1'h1, 8'hFC, 32'hFFFF_FFFF);
		rc(OFS_STAT, STAT_RST);
		rc(8'hFC, 32'h0000_0000);
		rc(OFS_CTRL, 32'h0000_0000);
	endtask
	// Every page length and granularity code
	task t_mode;
		for (int i = 0; i < 4; i++) begin
			bus(1'h1, OFS_MODE, {26'h000_0000, i[1:0], 2'h0, i[1:0]});
			rc(OFS_MODE, {26'h000_0000, i[1:0], 2'h0, i[1:0]});
		end
		// A write with no byte lanes enabled leaves the mode alone
		avs_byteenable <= 4'h0;
		bus(1'h1, OFS_MODE, 32'h0000_0000);
		avs_byteenable <= 4'hF;
		rc(OFS_MODE, 32'h0000_0033);
	endtask
	// 256-byte sectors, one slow report, then 16-bit words
	task t_sect;
		bus(1'h1, OFS_MODE, 32'h0000_0013);
		i_npe_flash_model.cmd();
		i_npe_flash_model.rep(KIND_SINGLE, 1, 256, 13'h0123, 4'h5, 32'h0000_0000, 0);
		i_npe_flash_model.rep(KIND_CODE, 2, 256, 13'h0000, 4'h0, 32'hFF80_0000, 3);
		i_npe_flash_model.rep(KIND_MULTI, 3, 256, 13'h0000, 4'h0, 32'h0000_0000, 0);
		bus_wide16 <= 1'h1;
		@(posedge core_clk);
		i_npe_flash_model.rep(KIND_SINGLE, 4, 256, 13'h0000, 4'h0, 32'h0000_0000, 0);
		bus_wide16 <= 1'h0;
		rc(OFS_STAT, 32'h0001_5210);
		rc(OFS_PR1, 32'h0000_1235);
		rc(OFS_PR2, 32'h0080_0000);
		bus(1'h1, OFS_MODE, 32'h0000_0003);
		rc(OFS_STAT, 32'h0000_0000);
	endtask
	// 512-byte sectors up to the last one
	task t_half;
		bus(1'h1, OFS_MODE, 32'h0000_0023);
		i_npe_flash_model.cmd();
		i_npe_flash_model.rep(KIND_MULTI, 1, 512, 13'h0000, 4'h0, 32'h0000_0000, 0);
		i_npe_flash_model.rep(KIND_SINGLE, 7, 512, 13'h0000, 4'h0, 32'h0000_0000, 0);
		rc(OFS_STAT, 32'h1000_0050);
	endtask
	// Whole-page code error splits its mask over two results
	task t_page;
		bus(1'h1, OFS_MODE, 32'h0000_0003);
		i_npe_flash_model.cmd();
		i_npe_flash_model.rep(KIND_CODE, 0, 4096, 13'h0000, 4'h0, 32'h0004_0000, 0);
		rc(OFS_STAT, 32'h0000_0002);
		rc(OFS_PR0, 32'h0000_0000);
		rc(OFS_PR1, 32'h0000_0004);
	endtask
	// Software and command clears
	task t_clear;
		bus(1'h1, OFS_CTRL, 32'h0000_0000);
		rc(OFS_STAT, 32'h0000_0002);
		bus(1'h1, OFS_CTRL, 32'h0000_0001);
		rc(OFS_STAT, 32'h0000_0000);
		rc(OFS_PR1, 32'h0000_0000);
		i_npe_flash_model.rep(KIND_MULTI, 0, 4096, 13'h0000, 4'h0, 32'h0000_0000, 0);
		i_npe_flash_model.cmd();
		rc(OFS_STAT, 32'h0000_0000);
	endtask
	// Interrupt raised, masked and cleared
	task t_irq;
		// Every kind of event has been seen by now
		rc(OFS_IRQ_STAT, 32'h0000_000F);
		bus(1'h1, OFS_IRQ_STAT, 32'h0000_000F);
		rc(OFS_IRQ_STAT, 32'h0000_0000);
		bus(1'h1, OFS_IRQ_MASK, 32'h0000_0001);
		i_npe_flash_model.rep(KIND_SINGLE, 0, 4096, 13'h0000, 4'h0, 32'h0000_0000, 0);
		@(posedge core_clk);
		check({31'h0, irq}, 32'h0000_0001);
		rc(OFS_IRQ_STAT, 32'h0000_0009);
		bus(1'h1, OFS_IRQ_MASK, 32'h0000_0000);
		@(posedge core_clk);
		check({31'h0, irq}, 32'h0000_0000);
		bus(1'h1, OFS_IRQ_STAT, 32'h0000_0009);
		rc(OFS_IRQ_STAT, 32'h0000_0000);
	endtask
	initial begin
		core_clk = 1'h0;
		forever #2.5 core_clk = ~core_clk;
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		results;
	end
	initial begin
		rst_n = 1'h0;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		bus_wide16 = 1'h0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		t_regs;
		t_mode;
		t_sect;
		t_half;
		t_page;
		t_clear;
		t_irq;
		results;
	end
endmodule
bind npe_status npe_status_props i_npe_status_props (.core_clk, .rst_n, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.nand_cmd_seen, .chk_done, .parity_clear, .irq);
